// ### bench/cpg_board_model.sv
// Purpose: external oscillator and board trace for bus clock feedback
// Assumes: free-running external clock, no crystal
// Notes: feedback trace delay in ns
`timescale 1ns/100ps
module cpg_board_model #(
   parameter int HALF_NS = 40,
   parameter int FB_NS = 3
) (
   input wire logic bus_clock_output,
   output logic clock_input_pin,
   output logic bus_clock_feedback
);
   initial clock_input_pin = 1'b0;
   // external oscillator, crystal select strapped low by the bench
   always #(HALF_NS) clock_input_pin = ~clock_input_pin;
   assign #(FB_NS) bus_clock_feedback = bus_clock_output;
endmodule

// ### bench/cpg_monitor.sv
// Purpose: port checks for the clock pulse generator
// Assumes: bound to cpg_top, one clock domain
// Notes: expected figures come from the hand-over timing
`timescale 1ns/100ps
module cpg_monitor
   import cpg_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [31:0] addr,
   input wire logic wr,
   input wire logic rd,
   input wire logic [15:0] rdata,
   input wire logic crystal_select,
   input wire logic self_refresh,
   input wire logic crystal_output_pin,
   input wire logic clock_valid,
   input wire logic core_clk_en,
   input wire logic bus_clk_en,
   input wire logic periph_clk_en,
   input wire logic [7:0] module_clk_en,
   input wire logic interval_irq,
   input wire logic wdog_poweron_reset,
   input wire logic wdog_manual_reset
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   reset_valid_a: assert property ($fell(rst) |-> clock_valid)
      else $error("clock valid low after reset");
   refresh_valid_a: assert property ($rose(self_refresh) |-> ##[1:3] !clock_valid)
      else $error("clock valid high in self refresh");
   settle_stop_a: assert property (wr && addr == CPG_FREQ_CTRL_ADDR |->
      ##3 !core_clk_en && !bus_clk_en && !periph_clk_en && !clock_valid)
      else $error("enables running while settling");
   read_idle_a: assert property (!$past(rd) |-> rdata == 16'h0000)
      else $error("read data outside read slot");
   crystal_output_pin_quiet_a: assert property (!crystal_select [*6] |-> !crystal_output_pin)
      else $error("crystal drive with external clock");
   module_gate_a: assert property (|module_clk_en |-> periph_clk_en || $past(periph_clk_en))
      else $error("module enable without peripheral enable");
   irq_pulse_a: assert property (interval_irq |=> !interval_irq)
      else $error("interval pulse too long");
   wdog_pulse_a: assert property (wdog_poweron_reset || wdog_manual_reset |->
      !interval_irq && !(wdog_poweron_reset && wdog_manual_reset) ##1
      !(wdog_poweron_reset || wdog_manual_reset))
      else $error("watchdog reset pulse wrong");
endmodule
bind cpg_top cpg_monitor mon (.clk(clk), .rst(rst), .addr(addr), .wr(wr), .rd(rd), .rdata(rdata),
   .crystal_select(crystal_select), .self_refresh(self_refresh), .crystal_output_pin(crystal_output_pin),
   .clock_valid(clock_valid), .core_clk_en(core_clk_en), .bus_clk_en(bus_clk_en),
   .periph_clk_en(periph_clk_en), .module_clk_en(module_clk_en), .interval_irq(interval_irq),
   .wdog_poweron_reset(wdog_poweron_reset), .wdog_manual_reset(wdog_manual_reset));

// ### bench/tb_top.sv
// Purpose: self-checking bench for the clock pulse generator
// Assumes: board model supplies clock input and feedback
// Notes: one task per scenario
`timescale 1ns/100ps
module tb_top;
   import cpg_pkg::*;
   logic clk = 0, rst = 1, wr = 0, rd = 0, slp = 0, stb = 0, wake = 0, sref = 0;
   logic [31:0] addr = 0;
   logic [15:0] wdata = 0, rdata, rv;
   logic [2:0] md = 0;
   logic xin, fb, bco, cv, ce, be, pe, p1, p2, irq, wpr, wmr;
   logic [7:0] mce;
   int fails = 0, check_count = 0, k;
   int c[5];
   always #5 clk = ~clk;
   cpg_board_model brd (.bus_clock_output(bco), .clock_input_pin(xin), .bus_clock_feedback(fb));
   cpg_top dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .mode_select_bit0(md[0]), .mode_select_bit1(md[1]), .mode_select_bit2(md[2]),
      .crystal_select(1'b0), .clock_input_pin(xin), .bus_clock_feedback(fb), .sleep_req(slp),
      .standby_req(stb), .wake(wake), .self_refresh(sref), .crystal_output_pin(), .bus_clock_output(bco),
      .clock_valid(cv), .core_clk_en(ce), .bus_clk_en(be), .periph_clk_en(pe), .module_clk_en(mce),
      .pll1_run(p1), .pll2_run(p2), .interval_irq(irq), .wdog_poweron_reset(wpr), .wdog_manual_reset(wmr));
   // ***************************************
   // shared tasks
   // ***************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wreg(input logic [31:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rreg(input logic [31:0] a, output logic [15:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      d = rdata;
   endtask
   task automatic hold(ref logic s, input int n);
      k = 0;
      while (s !== 1'b1 && k < n) begin
         @(posedge clk);
         k++;
      end
   endtask
   task automatic cnt(input int n);
      c = '{default: 0};
      repeat (n) begin
         @(posedge clk);
         c[0] += ce;
         c[1] += be;
         c[2] += pe;
         c[3] += mce[0];
         c[4] += mce[1];
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ***************************************
   // scenarios
   // ***************************************
   task automatic t_modes();
      logic [15:0] fc[8] = '{16'h0E1A, 16'h0E23, 16'h0E13, 16'h0E13, 16'h0E0A, 16'h0E0A, 16'h0E1A, 16'h0E1A};
      for (int m = 0; m < 8; m++) begin
         rst <= 1'b1;
         md <= 3'(m);
         cyc(3);
         chk(16'(cv), 16'h0001);
         rst <= 1'b0;
         cyc(15);
         rreg(CPG_FREQ_CTRL_ADDR, rv);
         chk(rv, fc[m]);
         rreg(CPG_STATUS_ADDR, rv);
         chk(16'(rv[15:12]), (m == 2 || m == 4) ? 16'h0006 : 16'h000C);
      end
      $display("modes done");
   endtask
   task automatic t_regs();
      wreg(CPG_FREQ_CTRL_ADDR, 16'hF423);
      rreg(CPG_FREQ_CTRL_ADDR, rv);
      chk(rv, 16'h0423);
      cyc(4);
      chk(16'({p1, p2, bco}), 16'h0004);
      wreg(32'hFFC00020, 16'h5555);
      rreg(32'hFFC00020, rv);
      chk(rv, 16'h0000);
      wreg(CPG_FREQ_CTRL_ADDR, 16'h0E5C);
      hold(cv, 3000);
      chk(16'(cv), 16'h0001);
      rreg(CPG_STATUS_ADDR, rv);
      chk(16'(rv[7:6]), 16'h0003);
      wreg(CPG_MOD_STBY_ADDR, 16'h0001);
      cyc(4);
      cnt(96);
      chk(16'(c[0]), 16'd48);
      chk(16'(c[1]), 16'd24);
      chk(16'(c[2]), 16'd12);
      chk(16'(c[3] * 100 + c[4]), 16'd12);
      $display("registers and dividers done");
   endtask
   task automatic t_power();
      slp <= 1'b1;
      @(posedge clk);
      slp <= 1'b0;
      cyc(3);
      cnt(96);
      chk(16'(c[0] * 100 + c[1]), 16'd24);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      stb <= 1'b1;
      @(posedge clk);
      stb <= 1'b0;
      cyc(4);
      chk(16'({cv, p1, p2, ce, be, pe}), 16'h0000);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      hold(cv, 3000);
      chk(16'(cv), 16'h0001);
      sref <= 1'b1;
      cyc(4);
      chk(16'(cv), 16'h0000);
      sref <= 1'b0;
      hold(cv, 100);
      chk(16'(cv), 16'h0001);
      $display("power modes done");
   endtask
   task automatic t_timer();
      wreg(CPG_STAB_CTRL_ADDR, 16'h0080);
      wreg(CPG_STAB_COUNT_ADDR, 16'h00F0);
      hold(irq, 400);
      @(posedge clk);
      hold(irq, 5000);
      chk(16'(k + 1), 16'd256);
      wreg(CPG_STAB_CTRL_ADDR, 16'h0082);
      hold(irq, 5000);
      @(posedge clk);
      hold(irq, 5000);
      chk(16'(k + 1), 16'd4096);
      wreg(CPG_STAB_CTRL_ADDR, 16'h00C0);
      wreg(CPG_STAB_COUNT_ADDR, 16'h00F0);
      hold(wpr, 400);
      chk(16'(wpr), 16'h0001);
      wreg(CPG_STAB_CTRL_ADDR, 16'h00E0);
      wreg(CPG_STAB_COUNT_ADDR, 16'h00F0);
      hold(wmr, 400);
      chk(16'(wmr), 16'h0001);
      rreg(CPG_STAB_CTRL_ADDR, rv);
      chk(16'(rv[4]), 16'h0001);
      $display("timer done");
   endtask
   initial begin
      cyc(8);
      t_modes();
      t_regs();
      t_power();
      t_timer();
      conclude();
   end
   initial begin
      #300000;
      fails++;
      $display("ERROR %0t: timeout", $time);
      conclude();
   end
endmodule

// ### logic/cpg_clk_div.sv
// Purpose: turns an enable stream into a divided enable pulse
// Assumes: divisor at least one
// Notes: align restarts the count so the output lines up
`timescale 1ns/100ps
module cpg_clk_div #(
   parameter int W = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic en_in,
   input wire logic align,
   input wire logic [W-1:0] divisor,
   output logic en_out
);
   import cpg_pkg::*;

   logic [W-1:0] cnt_reg, cnt_next;
   logic en_next;

   always_comb begin
      cnt_next = cnt_reg;
      en_next = 1'b0;
      if (align) begin
         cnt_next = '0;
      end else if (en_in) begin
         if (cnt_reg >= divisor - W'(1)) begin
            cnt_next = '0;
            en_next = 1'b1;
         end else begin
            cnt_next = cnt_reg + W'(1);
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= '0;
         en_out <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         en_out <= en_next;
      end
   end
endmodule

// ### logic/cpg_pkg.sv
// Purpose: shared constants for the clock pulse generator
// Assumes: 100 MHz system clock, 16-bit register data
// Notes: register offsets are byte addresses
package cpg_pkg;

   // ***************************************
   // timing
   // ***************************************
   localparam int CPG_CLK_PERIOD_NS = 10;
   localparam int CPG_PLL_LOCK_NS = 200;
   localparam int CPG_PLL_LOCK_CYC = (CPG_PLL_LOCK_NS + CPG_CLK_PERIOD_NS - 1) / CPG_CLK_PERIOD_NS;
   localparam int CPG_STRAP_CYC = 3;
   // three sync stages plus the agree stage
   localparam int CPG_FB_DELAY = 4;

   // ***************************************
   // register map
   // ***************************************
   localparam logic [31:0] CPG_FREQ_CTRL_ADDR = 32'hFFC00000;
   localparam logic [31:0] CPG_STAB_CTRL_ADDR = 32'hFFC00004;
   localparam logic [31:0] CPG_STAB_COUNT_ADDR = 32'hFFC00008;
   localparam logic [31:0] CPG_MOD_STBY_ADDR = 32'hFFC0000C;
   localparam logic [31:0] CPG_STATUS_ADDR = 32'hFFC00010;

   // frequency_control fields
   localparam int CPG_FC_BUS_CLOCK_OUTPUT_EN_BIT = 11;
   localparam int CPG_FC_PLL1_BIT = 10;
   localparam int CPG_FC_PLL2_BIT = 9;
   localparam int CPG_FC_CORE_LSB = 6;
   localparam int CPG_FC_BUS_LSB = 3;
   localparam int CPG_FC_PER_LSB = 0;
   localparam logic [15:0] CPG_FC_WR_MASK = 16'h0FFF;

   // frequency_control value after power-on, per clock mode
   localparam logic [15:0] CPG_FC_INIT_M0 = 16'h0E1A;
   localparam logic [15:0] CPG_FC_INIT_M1 = 16'h0E23;
   localparam logic [15:0] CPG_FC_INIT_M2 = 16'h0E13;
   localparam logic [15:0] CPG_FC_INIT_M3 = 16'h0E13;
   localparam logic [15:0] CPG_FC_INIT_M4 = 16'h0E0A;
   localparam logic [15:0] CPG_FC_INIT_M5 = 16'h0E0A;
   localparam logic [3:0] CPG_MULT_LOW = 4'h6;
   localparam logic [3:0] CPG_MULT_HIGH = 4'hC;

   // stabilization timer control fields
   localparam int CPG_SC_EN_BIT = 7;
   localparam int CPG_SC_WDOG_BIT = 6;
   localparam int CPG_SC_MANUAL_BIT = 5;
   localparam int CPG_SC_OVF_BIT = 4;
   localparam int CPG_SC_CKS_LSB = 0;
   localparam logic [7:0] CPG_SC_RESET = 8'h00;
   localparam logic [7:0] CPG_MOD_STBY_RESET = 8'h00;
   localparam logic [11:0] CPG_PRESC_MAX_MASK = 12'hFFF;

   typedef enum logic [3:0] {
      CPG_ST_RUN = 4'b0001,
      CPG_ST_SLEEP = 4'b0010,
      CPG_ST_STBY = 4'b0100,
      CPG_ST_SETTLE = 4'b1000
   } cpg_state_e;

endpackage

// ### logic/cpg_stab_timer.sv
// Purpose: prescaled up-counter for settling time, watchdog and interval use
// Assumes: tick_x1 is the undivided x1 enable with PLL1 on, and high every clk cycle with PLL1 off
// Notes: settle_start clears counter and prescaler; settling forces counting
`timescale 1ns/100ps
module cpg_stab_timer (
   input wire logic clk,
   input wire logic rst,
   input wire logic tick_x1,
   input wire logic enable,
   input wire logic settle_start,
   input wire logic settling,
   input wire logic [2:0] cks,
   input wire logic wr_count,
   input wire logic [7:0] wdata,
   output logic [7:0] count,
   output logic overflow
);
   import cpg_pkg::*;

   logic [11:0] presc_reg, presc_next, mask;
   logic [7:0] cnt_next;
   logic ovf_next, step;

   // eight input clocks scaled from x1
   always_comb begin
      case (cks)
         3'h0: mask = 12'h000;
         3'h1: mask = 12'h003;
         3'h2: mask = 12'h00F;
         3'h3: mask = 12'h01F;
         3'h4: mask = 12'h03F;
         3'h5: mask = 12'h0FF;
         3'h6: mask = 12'h3FF;
         default: mask = CPG_PRESC_MAX_MASK;
      endcase
   end

   always_comb begin
      presc_next = presc_reg;
      cnt_next = count;
      ovf_next = 1'b0;
      step = tick_x1 && (enable || settling) && ((presc_reg & mask) == mask);
      if (settle_start) begin
         presc_next = '0;
         cnt_next = '0;
      end else if (wr_count) begin
         cnt_next = wdata;
      end else begin
         if (tick_x1 && (enable || settling)) begin
            presc_next = presc_reg + 12'h001;
         end
         if (step) begin
            cnt_next = count + 8'h01;
            ovf_next = (count == 8'hFF);
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         presc_reg <= '0;
         count <= '0;
         overflow <= 1'b0;
      end else begin
         presc_reg <= presc_next;
         count <= cnt_next;
         overflow <= ovf_next;
      end
   end
endmodule

// ### logic/cpg_top.sv
// What this block does
// - PLL1 multiplies input by 6 or 12
// - internal clock edge aligned to input edge
// - each PLL runs per its control bit
// - PLL2 aligns bus clock to fed-back pin
// - without PLL1, input halved for 50% duty
// - divider makes core, bus, peripheral clocks
// - three ratios changed independently by software
// - mode pins pick one of six modes
// - clock valid low when unstable or self-refresh
// - power-on reset sets clock valid high
// - bus clock pin toggles or holds fixed
// - core clock stops in sleep; clocks stop in standby, module clocks in module standby
// - standby logic governs oscillators during switching
// - timer counts settling before clocks released
// - watchdog overflow gives power-on or manual reset
// - interval mode raises interrupt on overflow
// - timer clock one of eight prescaled clocks
// - control register loaded from mode pins only at power-on
// Purpose: clock pulse generator with register port and stabilization timer
// Assumes: rst is the power-on reset; clk stands for the PLL output
// Notes: all derived clocks except bus_clock_output are one-cycle enables
`timescale 1ns/100ps
module cpg_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic [31:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   input wire logic mode_select_bit0,
   input wire logic mode_select_bit1,
   input wire logic mode_select_bit2,
   input wire logic crystal_select,
   input wire logic clock_input_pin,
   input wire logic bus_clock_feedback,
   input wire logic sleep_req,
   input wire logic standby_req,
   input wire logic wake,
   input wire logic self_refresh,
   output logic crystal_output_pin,
   output logic bus_clock_output,
   output logic clock_valid,
   output logic core_clk_en,
   output logic bus_clk_en,
   output logic periph_clk_en,
   output logic [7:0] module_clk_en,
   output logic pll1_run,
   output logic pll2_run,
   output logic interval_irq,
   output logic wdog_poweron_reset,
   output logic wdog_manual_reset
);
   import cpg_pkg::*;

   // ***************************************
   // pin synchronisers
   // ***************************************
   localparam int NPIN = 6;
   logic [NPIN-1:0] pin_raw, s1_reg, s2_reg, s3_reg, filt_reg;
   assign pin_raw = {bus_clock_feedback, clock_input_pin, crystal_select,
                     mode_select_bit2, mode_select_bit1, mode_select_bit0};

   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_sync
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               s1_reg[gi] <= 1'b0;
               s2_reg[gi] <= 1'b0;
               s3_reg[gi] <= 1'b0;
               filt_reg[gi] <= 1'b0;
            end else begin
               s1_reg[gi] <= pin_raw[gi];
               s2_reg[gi] <= s1_reg[gi];
               s3_reg[gi] <= s2_reg[gi];
               if (s2_reg[gi] == s3_reg[gi]) begin
                  filt_reg[gi] <= s3_reg[gi];
               end
            end
         end
      end
   endgenerate

   logic [2:0] mode_pins;
   logic crystal_output_pin_sel, in_lvl, fb_lvl;
   assign mode_pins = filt_reg[2:0];
   assign crystal_output_pin_sel = filt_reg[3];
   assign in_lvl = filt_reg[4];
   assign fb_lvl = filt_reg[5];

   // ***************************************
   // state and registers
   // ***************************************
   cpg_state_e st_reg, st_next;
   logic [15:0] fc_reg, fc_next;
   logic [7:0] sc_reg, sc_next, ms_reg, ms_next;
   logic [1:0] strap_cnt_reg, strap_cnt_next;
   logic strap_done_reg, strap_done_next;
   logic [3:0] mult_reg, mult_next;
   logic [7:0] lock1_reg, lock1_next, lock2_reg, lock2_next;
   logic in_prev_reg, half_reg, half_next, aligned_reg, aligned_next;
   logic [CPG_FB_DELAY-1:0] bus_clock_output_dly_reg;
   logic pll2_ok_reg, pll2_ok_next;
   logic [7:0] tmr_count;
   logic tmr_ovf, settle_start, base_en, align, in_rise;
   logic div_core, div_bus, div_per;
   logic sel_fc, sel_sc, sel_cnt, sel_ms, sel_st;
   logic [15:0] rdata_next;

   // ***************************************
   // ratio decode
   // ***************************************
   function automatic logic [3:0] ratio_fast(input logic [2:0] code);
      case (code)
         3'h0: ratio_fast = 4'h1;
         3'h1: ratio_fast = 4'h2;
         3'h2: ratio_fast = 4'h3;
         3'h3: ratio_fast = 4'h4;
         3'h4: ratio_fast = 4'h6;
         3'h5: ratio_fast = 4'h8;
         default: ratio_fast = 4'h1;
      endcase
   endfunction

   function automatic logic [3:0] ratio_per(input logic [2:0] code);
      case (code)
         3'h0: ratio_per = 4'h2;
         3'h1: ratio_per = 4'h3;
         3'h2: ratio_per = 4'h4;
         3'h3: ratio_per = 4'h6;
         3'h4: ratio_per = 4'h8;
         default: ratio_per = 4'h2;
      endcase
   endfunction

   function automatic logic [15:0] mode_init(input logic [2:0] m);
      case (m)
         3'h1: mode_init = CPG_FC_INIT_M1;
         3'h2: mode_init = CPG_FC_INIT_M2;
         3'h3: mode_init = CPG_FC_INIT_M3;
         3'h4: mode_init = CPG_FC_INIT_M4;
         3'h5: mode_init = CPG_FC_INIT_M5;
         default: mode_init = CPG_FC_INIT_M0;
      endcase
   endfunction

   // ***************************************
   // address decode
   // ***************************************
   always_comb begin
      sel_fc = 1'b0;
      sel_sc = 1'b0;
      sel_cnt = 1'b0;
      sel_ms = 1'b0;
      sel_st = 1'b0;
      if (addr == CPG_FREQ_CTRL_ADDR) begin
         sel_fc = 1'b1;
      end else if (addr == CPG_STAB_CTRL_ADDR) begin
         sel_sc = 1'b1;
      end else if (addr == CPG_STAB_COUNT_ADDR) begin
         sel_cnt = 1'b1;
      end else if (addr == CPG_MOD_STBY_ADDR) begin
         sel_ms = 1'b1;
      end else if (addr == CPG_STATUS_ADDR) begin
         sel_st = 1'b1;
      end
   end

   // ***************************************
   // clock generation
   // ***************************************
   logic pll1_on, pll2_on, stopped;
   assign stopped = (st_reg == CPG_ST_STBY);
   assign pll1_on = fc_reg[CPG_FC_PLL1_BIT] && !stopped;
   assign pll2_on = fc_reg[CPG_FC_PLL2_BIT] && !stopped;
   assign in_rise = in_lvl && !in_prev_reg;
   // without PLL1, every second input rising edge gives a 50% duty x1 clock
   assign base_en = pll1_on ? (lock1_reg == 8'(CPG_PLL_LOCK_CYC)) : (in_rise && half_reg);
   // restart the dividers on the first input rising edge after lock
   assign align = pll1_on && (lock1_reg == 8'(CPG_PLL_LOCK_CYC)) && in_rise && !aligned_reg;

   always_comb begin
      lock1_next = lock1_reg;
      lock2_next = lock2_reg;
      half_next = half_reg;
      aligned_next = aligned_reg;
      pll2_ok_next = 1'b0;
      if (!pll1_on) begin
         lock1_next = '0;
         aligned_next = 1'b0;
      end else if (lock1_reg != 8'(CPG_PLL_LOCK_CYC)) begin
         lock1_next = lock1_reg + 8'h01;
      end else if (align) begin
         aligned_next = 1'b1;
      end
      if (!pll2_on) begin
         lock2_next = '0;
      end else if (lock2_reg != 8'(CPG_PLL_LOCK_CYC)) begin
         lock2_next = lock2_reg + 8'h01;
      end
      if (in_rise) begin
         half_next = !half_reg;
      end
      // fed-back bus clock must match what was driven, round-trip delayed
      if (pll2_on && lock2_reg == 8'(CPG_PLL_LOCK_CYC)) begin
         pll2_ok_next = (fb_lvl == bus_clock_output_dly_reg[CPG_FB_DELAY-1]);
      end
   end

   cpg_clk_div u_div_core (.clk(clk), .rst(rst), .en_in(base_en), .align(align),
      .divisor(ratio_fast(fc_reg[CPG_FC_CORE_LSB +: 3])), .en_out(div_core));
   cpg_clk_div u_div_bus (.clk(clk), .rst(rst), .en_in(base_en), .align(align),
      .divisor(ratio_fast(fc_reg[CPG_FC_BUS_LSB +: 3])), .en_out(div_bus));
   cpg_clk_div u_div_per (.clk(clk), .rst(rst), .en_in(base_en), .align(align),
      .divisor(ratio_per(fc_reg[CPG_FC_PER_LSB +: 3])), .en_out(div_per));

   cpg_stab_timer u_timer (.clk(clk), .rst(rst), .tick_x1(base_en || !pll1_on),
      .enable(sc_reg[CPG_SC_EN_BIT]), .settle_start(settle_start),
      .settling(st_reg == CPG_ST_SETTLE), .cks(sc_reg[CPG_SC_CKS_LSB +: 3]),
      .wr_count(wr && sel_cnt), .wdata(wdata[7:0]), .count(tmr_count), .overflow(tmr_ovf));

   // ***************************************
   // control next state
   // ***************************************
   always_comb begin
      st_next = st_reg;
      fc_next = fc_reg;
      sc_next = sc_reg;
      ms_next = ms_reg;
      mult_next = mult_reg;
      strap_cnt_next = strap_cnt_reg;
      strap_done_next = strap_done_reg;
      settle_start = 1'b0;
      // straps caught once the agree stage holds what the last stage holds
      if (!strap_done_reg) begin
         if (strap_cnt_reg != 2'(CPG_STRAP_CYC)) begin
            strap_cnt_next = strap_cnt_reg + 2'h1;
         end else if (s3_reg[2:0] == filt_reg[2:0]) begin
            strap_done_next = 1'b1;
            fc_next = mode_init(mode_pins);
            mult_next = (mode_pins == 3'h2 || mode_pins == 3'h4) ? CPG_MULT_LOW : CPG_MULT_HIGH;
         end
      end
      if (wr && sel_fc) begin
         fc_next = wdata & CPG_FC_WR_MASK;
      end
      if (wr && sel_sc) begin
         sc_next = wdata[7:0];
         sc_next[CPG_SC_OVF_BIT] = sc_reg[CPG_SC_OVF_BIT] & wdata[CPG_SC_OVF_BIT];
      end
      if (tmr_ovf && st_reg != CPG_ST_SETTLE) begin
         sc_next[CPG_SC_OVF_BIT] = 1'b1; // set wins over clear
      end
      if (wr && sel_ms) begin
         ms_next = wdata[7:0];
      end
      case (st_reg)
         CPG_ST_RUN: begin
            if (wr && sel_fc) begin
               st_next = CPG_ST_SETTLE;
               settle_start = 1'b1;
            end else if (standby_req) begin
               st_next = CPG_ST_STBY;
            end else if (sleep_req) begin
               st_next = CPG_ST_SLEEP;
            end
         end
         CPG_ST_SLEEP: begin
            if (wake) begin
               st_next = CPG_ST_RUN;
            end
         end
         CPG_ST_STBY: begin
            if (wake) begin
               st_next = CPG_ST_SETTLE;
               settle_start = 1'b1;
            end
         end
         CPG_ST_SETTLE: begin
            if (tmr_ovf) begin
               st_next = CPG_ST_RUN;
            end
         end
         default: st_next = CPG_ST_RUN;
      endcase
   end

   // ***************************************
   // outputs next values
   // ***************************************
   logic run, bus_stable;
   logic bus_clock_output_next, cv_next, xo_next;
   assign run = (st_reg == CPG_ST_RUN);
   assign bus_stable = (run || st_reg == CPG_ST_SLEEP) && (!pll2_on || pll2_ok_reg);

   always_comb begin
      bus_clock_output_next = bus_clock_output;
      if (!fc_reg[CPG_FC_BUS_CLOCK_OUTPUT_EN_BIT] || stopped) begin
         bus_clock_output_next = 1'b0;
      end else if (div_bus) begin
         bus_clock_output_next = !bus_clock_output;
      end
      cv_next = bus_stable && !self_refresh;
      xo_next = crystal_output_pin_sel ? !in_lvl : 1'b0;
      rdata_next = '0;
      if (rd) begin
         if (sel_fc) begin
            rdata_next = fc_reg;
         end else if (sel_sc) begin
            rdata_next = {8'h00, sc_reg};
         end else if (sel_cnt) begin
            rdata_next = {8'h00, tmr_count};
         end else if (sel_ms) begin
            rdata_next = {8'h00, ms_reg};
         end else if (sel_st) begin
            rdata_next = {mult_reg, 3'h0, crystal_output_pin_sel, pll2_ok_reg, aligned_reg, strap_done_reg, st_reg, 1'b0};
         end
      end
   end

   // ***************************************
   // registers
   // ***************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_reg <= CPG_ST_RUN;
         fc_reg <= CPG_FC_INIT_M0;
         sc_reg <= CPG_SC_RESET;
         ms_reg <= CPG_MOD_STBY_RESET;
         mult_reg <= CPG_MULT_HIGH;
         strap_cnt_reg <= '0;
         strap_done_reg <= 1'b0;
         lock1_reg <= '0;
         lock2_reg <= '0;
         in_prev_reg <= 1'b0;
         half_reg <= 1'b0;
         aligned_reg <= 1'b0;
         bus_clock_output_dly_reg <= '0;
         pll2_ok_reg <= 1'b0;
         rdata <= '0;
         crystal_output_pin <= 1'b0;
         bus_clock_output <= 1'b0;
         clock_valid <= 1'b1;
         core_clk_en <= 1'b0;
         bus_clk_en <= 1'b0;
         periph_clk_en <= 1'b0;
         module_clk_en <= '0;
         pll1_run <= 1'b0;
         pll2_run <= 1'b0;
         interval_irq <= 1'b0;
         wdog_poweron_reset <= 1'b0;
         wdog_manual_reset <= 1'b0;
      end else begin
         st_reg <= st_next;
         fc_reg <= fc_next;
         sc_reg <= sc_next;
         ms_reg <= ms_next;
         mult_reg <= mult_next;
         strap_cnt_reg <= strap_cnt_next;
         strap_done_reg <= strap_done_next;
         lock1_reg <= lock1_next;
         lock2_reg <= lock2_next;
         in_prev_reg <= in_lvl;
         half_reg <= half_next;
         aligned_reg <= aligned_next;
         bus_clock_output_dly_reg <= {bus_clock_output_dly_reg[CPG_FB_DELAY-2:0], bus_clock_output};
         pll2_ok_reg <= pll2_ok_next;
         rdata <= rdata_next;
         crystal_output_pin <= xo_next;
         bus_clock_output <= bus_clock_output_next;
         clock_valid <= cv_next;
         core_clk_en <= div_core && run && strap_done_reg;
         bus_clk_en <= div_bus && bus_stable && strap_done_reg;
         periph_clk_en <= div_per && bus_stable && strap_done_reg;
         module_clk_en <= (div_per && bus_stable && strap_done_reg) ? ~ms_reg : 8'h00;
         pll1_run <= pll1_on;
         pll2_run <= pll2_on;
         interval_irq <= tmr_ovf && sc_reg[CPG_SC_EN_BIT] && !sc_reg[CPG_SC_WDOG_BIT]
            && st_reg != CPG_ST_SETTLE;
         wdog_poweron_reset <= tmr_ovf && sc_reg[CPG_SC_EN_BIT] && sc_reg[CPG_SC_WDOG_BIT]
            && !sc_reg[CPG_SC_MANUAL_BIT] && st_reg != CPG_ST_SETTLE;
         wdog_manual_reset <= tmr_ovf && sc_reg[CPG_SC_EN_BIT] && sc_reg[CPG_SC_WDOG_BIT]
            && sc_reg[CPG_SC_MANUAL_BIT] && st_reg != CPG_ST_SETTLE;
      end
   end
endmodule
